/* hw/spi_eeprom_access_protect.sv */
`timescale 1ns/1ps
// Functional notes
// - Status bit 0 reads 1 while a write cycle runs, else 0.
// - Status bit 1 shows the write-enable latch.
// - Status bits 4 to 6 read zero when idle.
// - During a write cycle the whole status byte reads all ones.
// - Two block-protect bits select none, top quarter, top half or all.
// - Addresses inside the protected segment are never programmed.
// - Protect bits need the enable latch and a timed write cycle to change.
// - Hardware protection is on exactly when the pin is low and pin enable set.
// - Hardware protection rejects status writes but allows unprotected array writes.
// - Pin enable cannot be cleared while the protect pin stays low.
// - Writes without the enable latch are ignored until select rises.
// - Read: opcode, address, then data shifts out MSB first, input ignored.
// - Address is two bytes; only the low 15 bits are used.
// - Continued read increments the address and wraps to zero.
// - Programming starts only after select returns high.
// - During a write cycle only the status read is honoured.
// - Page write increments only the six low address bits.
// - More than 64 bytes wrap within the page and overwrite.
// - The enable latch clears when each write cycle completes.
// - An ignored instruction waits for a new select falling edge.
// - Eight-bit opcodes with bit 3 don't care.
// - All bits travel most significant bit first.
// - Unknown opcode: no further input, output stays off until reselect.
module spi_eeprom_access_protect
  import eeprom_pkg::*;
#(
  parameter int unsigned WRITE_CYCLE_CYCLES_P = WRITE_CYCLE_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic write_busy
);

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Protected segment test for a given level and address.
  function automatic logic addr_protected(input logic [1:0] level,
                                          input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    case (level)
      BP_QUARTER: hit = (addr[ADDR_W-1:ADDR_W-2] == 2'b11);
      BP_HALF: hit = addr[ADDR_W-1];
      BP_ALL: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Opcode compare with the don't-care bit masked off.
  function automatic logic op_is(input logic [7:0] code, input logic [7:0] ref_code);
    return (code & OPCODE_MASK) == ref_code;
  endfunction

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] page_buf [0:PAGE_BYTES-1];

  // ****************************************************************
  // Link domain declarations.
  // ****************************************************************
  link_state_t state_r;
  link_state_t state_nxt;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] addr_hi_r;
  logic addr_byte_r;
  logic [ADDR_W-1:0] cur_addr_r;
  logic enable_latch_r;
  logic commit_ok_r;
  commit_kind_t commit_kind_r;
  logic [PAGE_BYTES-1:0] mask_r;
  logic [7:0] sr_data_r;
  logic busy_s1_r;
  logic busy_s2_r;
  logic done_s1_r;
  logic done_s2_r;
  logic done_s3_r;
  logic wp_s1_r;
  logic wp_s2_r;
  nv_status_t nv_s1_r;
  nv_status_t nv_s2_r;
  logic so_r;
  logic so_oe_r;
  logic [7:0] tx_r;

  logic frame_rst_n;
  logic [7:0] shift_nxt;
  logic byte_done;
  logic [15:0] addr_word;
  logic [ADDR_W-1:0] rx_addr;
  logic hw_prot_link;
  logic [7:0] status_byte;
  logic [7:0] tx_load;
  logic out_active;
  logic op_accept_write;
  logic op_accept_status;
  logic buf_we;
  logic latch_set;
  logic latch_clr;
  logic done_evt;

  // ****************************************************************
  // Clock domain declarations.
  // ****************************************************************
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_s3_r;
  logic wp_c1_r;
  logic wp_c2_r;
  logic busy_r;
  logic [31:0] timer_r;
  logic [6:0] idx_r;
  commit_kind_t kind_c_r;
  logic sr_ok_r;
  logic done_tgl_r;
  nv_status_t nv_r;
  logic cs_rise;
  logic start_cycle;
  logic finish_cycle;
  logic hw_prot_clk;
  logic mem_we;
  logic [ADDR_W-1:0] mem_waddr;

  // ****************************************************************
  // Link side decode.
  // ****************************************************************

  // The frame logic restarts whenever select is high, so every new
  // instruction begins from a fresh falling edge of select.
  assign frame_rst_n = arst_n & ~cs_n;
  assign shift_nxt = {shift_r[6:0], si};
  assign byte_done = (bit_cnt_r == 3'd7);
  assign addr_word = {addr_hi_r, shift_nxt};
  assign rx_addr = addr_word[ADDR_W-1:0];
  assign hw_prot_link = ~wp_s2_r & nv_s2_r.protect_pin_enable;
  assign op_accept_write = enable_latch_r;
  assign op_accept_status = enable_latch_r & ~hw_prot_link;

  // Status byte; a busy device reads all ones.
  assign status_byte = busy_s2_r ? STATUS_BUSY_VALUE :
    {nv_s2_r.protect_pin_enable, 3'b000, nv_s2_r.block_protect_high,
     nv_s2_r.block_protect_low, enable_latch_r, 1'b0};

  // Opcode decode into the next phase of the frame.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OPCODE: begin
        if (byte_done) begin
          if (op_is(shift_nxt, OP_READ_STATUS)) begin
            state_nxt = ST_STATUS_OUT;
          end else if (busy_s2_r) begin
            state_nxt = ST_IGNORE;
          end else if (op_is(shift_nxt, OP_READ_ARRAY)) begin
            state_nxt = ST_ADDRESS;
          end else if (op_is(shift_nxt, OP_WRITE_ARRAY)) begin
            state_nxt = op_accept_write ? ST_ADDRESS : ST_IGNORE;
          end else if (op_is(shift_nxt, OP_WRITE_STATUS)) begin
            state_nxt = op_accept_status ? ST_STATUS_IN : ST_IGNORE;
          end else if (op_is(shift_nxt, OP_SET_ENABLE_LATCH) ||
                       op_is(shift_nxt, OP_CLEAR_ENABLE_LATCH)) begin
            state_nxt = ST_IGNORE;
          end else begin
            state_nxt = ST_IGNORE;
          end
        end
      end
      ST_ADDRESS: begin
        if (byte_done && addr_byte_r) begin
          state_nxt = (commit_kind_r == KIND_ARRAY) ? ST_WRITE_IN : ST_READ_OUT;
        end
      end
      ST_READ_OUT: state_nxt = ST_READ_OUT;
      ST_WRITE_IN: state_nxt = ST_WRITE_IN;
      ST_STATUS_OUT: state_nxt = ST_STATUS_OUT;
      ST_STATUS_IN: state_nxt = ST_STATUS_IN;
      ST_IGNORE: state_nxt = ST_IGNORE;
      default: state_nxt = ST_IGNORE;
    endcase
  end

  // Enable latch controls; a set in the same edge as a clear wins.
  assign latch_set = (state_r == ST_OPCODE) & byte_done & ~busy_s2_r &
    op_is(shift_nxt, OP_SET_ENABLE_LATCH);
  assign latch_clr = ((state_r == ST_OPCODE) & byte_done & ~busy_s2_r &
    op_is(shift_nxt, OP_CLEAR_ENABLE_LATCH)) | done_evt;
  assign done_evt = done_s2_r ^ done_s3_r;

  // Only bytes outside the protected segment enter the page buffer.
  assign buf_we = (state_r == ST_WRITE_IN) & byte_done &
    ~addr_protected({nv_s2_r.block_protect_high, nv_s2_r.block_protect_low},
                    cur_addr_r);

  // ****************************************************************
  // Link side registers, sampled on rising clock edges.
  // ****************************************************************

  // Frame sequencing registers, cleared while deselected.
  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state_r <= ST_OPCODE;
      bit_cnt_r <= 3'd0;
      shift_r <= 8'h00;
      addr_hi_r <= 8'h00;
      addr_byte_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_r + 3'd1;
      shift_r <= shift_nxt;
      if (state_r == ST_ADDRESS && byte_done) begin
        addr_byte_r <= ~addr_byte_r;
        addr_hi_r <= shift_nxt;
      end
    end
  end

  // Commit state survives deselect so the clock side can pick it up.
  // Any bit that does not close a data byte withdraws the commit.
  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      commit_ok_r <= 1'b0;
      commit_kind_r <= KIND_NONE;
    end else begin
      commit_ok_r <= 1'b0;
      if (state_r == ST_OPCODE && byte_done) begin
        commit_kind_r <= KIND_NONE;
        if (!busy_s2_r && op_is(shift_nxt, OP_WRITE_ARRAY) && op_accept_write) begin
          commit_kind_r <= KIND_ARRAY;
        end else if (!busy_s2_r && op_is(shift_nxt, OP_WRITE_STATUS) &&
                     op_accept_status) begin
          commit_kind_r <= KIND_STATUS;
        end
      end else if ((state_r == ST_WRITE_IN || state_r == ST_STATUS_IN) && byte_done) begin
        commit_ok_r <= 1'b1;
      end
    end
  end

  // Address counter: full wrap on reads, page wrap on writes.
  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      cur_addr_r <= '0;
    end else if (state_r == ST_ADDRESS && byte_done && addr_byte_r) begin
      cur_addr_r <= rx_addr;
    end else if (state_r == ST_READ_OUT && byte_done) begin
      cur_addr_r <= cur_addr_r + 15'd1;
    end else if (state_r == ST_WRITE_IN && byte_done) begin
      cur_addr_r[PAGE_W-1:0] <= cur_addr_r[PAGE_W-1:0] + 6'd1;
    end
  end

  // Page mask, status data and the enable latch.
  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      mask_r <= '0;
      sr_data_r <= 8'h00;
      enable_latch_r <= ENABLE_LATCH_RESET;
    end else begin
      if (state_r == ST_ADDRESS && commit_kind_r == KIND_ARRAY && byte_done &&
          addr_byte_r) begin
        mask_r <= '0;
      end else if (buf_we) begin
        mask_r[cur_addr_r[PAGE_W-1:0]] <= 1'b1;
      end
      if (state_r == ST_STATUS_IN && byte_done) begin
        sr_data_r <= shift_nxt;
      end
      if (latch_set) begin
        enable_latch_r <= 1'b1;
      end else if (latch_clr) begin
        enable_latch_r <= 1'b0;
      end
    end
  end

  // Page buffer bytes; a later byte at the same slot overwrites.
  always_ff @(posedge sck) begin
    if (buf_we) begin
      page_buf[cur_addr_r[PAGE_W-1:0]] <= shift_nxt;
    end
  end

  // Synchronisers into the link domain. They only advance on clock
  // edges, so the opcode byte gives them time to settle.
  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      done_s3_r <= 1'b0;
      wp_s1_r <= 1'b1;
      wp_s2_r <= 1'b1;
      nv_s1_r <= NV_RESET;
      nv_s2_r <= NV_RESET;
    end else begin
      busy_s1_r <= busy_r;
      busy_s2_r <= busy_s1_r;
      done_s1_r <= done_tgl_r;
      done_s2_r <= done_s1_r;
      done_s3_r <= done_s2_r;
      wp_s1_r <= wp_n;
      wp_s2_r <= wp_s1_r;
      nv_s1_r <= nv_r;
      nv_s2_r <= nv_s1_r;
    end
  end

  // ****************************************************************
  // Serial output, changed on falling clock edges.
  // ****************************************************************

  // The array is read without a crossing: no array write runs while a
  // read frame can reach this point, so the word is steady.
  assign out_active = (state_r == ST_READ_OUT) | (state_r == ST_STATUS_OUT);
  assign tx_load = (state_r == ST_READ_OUT) ? mem[cur_addr_r] : status_byte;

  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
      tx_r <= 8'h00;
    end else if (out_active) begin
      so_oe_r <= 1'b1;
      if (bit_cnt_r == 3'd0) begin
        so_r <= tx_load[7];
        tx_r <= {tx_load[6:0], 1'b0};
      end else begin
        so_r <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end else begin
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end
  end

  assign so = so_r;
  assign so_oe = so_oe_r;

  // ****************************************************************
  // Clock domain: write-cycle engine.
  // ****************************************************************

  // Commit fields from the link side are steady once select is high,
  // because the link clock is then still; the synchronised select edge
  // is what makes them safe to sample.
  assign cs_rise = cs_s2_r & ~cs_s3_r;
  assign hw_prot_clk = ~wp_c2_r & nv_r.protect_pin_enable;
  assign start_cycle = cs_rise & ~busy_r & commit_ok_r &
    (commit_kind_r != KIND_NONE);
  assign finish_cycle = busy_r & (timer_r == WRITE_CYCLE_CYCLES_P - 32'd1);
  assign mem_we = busy_r & (kind_c_r == KIND_ARRAY) & ~idx_r[6] &
    mask_r[idx_r[PAGE_W-1:0]];
  assign mem_waddr = {cur_addr_r[ADDR_W-1:PAGE_W], idx_r[PAGE_W-1:0]};

  // Pin synchronisers.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      wp_c1_r <= 1'b1;
      wp_c2_r <= 1'b1;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      wp_c1_r <= wp_n;
      wp_c2_r <= wp_c1_r;
    end
  end

  // Busy timer and page copy; one buffer slot moves per cycle, so the
  // cycle must last at least one page of clocks.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
      timer_r <= 32'd0;
      idx_r <= 7'd0;
      kind_c_r <= KIND_NONE;
      sr_ok_r <= 1'b0;
      done_tgl_r <= 1'b0;
    end else if (start_cycle) begin
      busy_r <= 1'b1;
      timer_r <= 32'd0;
      idx_r <= 7'd0;
      kind_c_r <= commit_kind_r;
      sr_ok_r <= ~hw_prot_clk;
    end else if (finish_cycle) begin
      busy_r <= 1'b0;
      done_tgl_r <= ~done_tgl_r;
    end else if (busy_r) begin
      timer_r <= timer_r + 32'd1;
      if (!idx_r[6]) begin
        idx_r <= idx_r + 7'd1;
      end
    end
  end

  // Nonvolatile protect bits change only at the end of a status cycle.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      nv_r <= NV_RESET;
    end else if (finish_cycle && kind_c_r == KIND_STATUS && sr_ok_r) begin
      nv_r.protect_pin_enable <= sr_data_r[ST_PIN_ENABLE_BIT];
      nv_r.block_protect_high <= sr_data_r[ST_BP_HIGH_BIT];
      nv_r.block_protect_low <= sr_data_r[ST_BP_LOW_BIT];
    end
  end

  // Array programming from the page buffer.
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_waddr] <= page_buf[idx_r[PAGE_W-1:0]];
    end
  end

  assign write_busy = busy_r;

endmodule

/* hw/eeprom_pkg.sv */
package eeprom_pkg;

  // ****************************************************************
  // Geometry of the array and the page buffer.
  // ****************************************************************
  localparam int ADDR_W = 15;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int DATA_W = 8;

  // ****************************************************************
  // Instruction codes; bit 3 of every opcode is masked before compare.
  // ****************************************************************
  localparam logic [7:0] OPCODE_MASK = 8'hF7;
  localparam logic [7:0] OP_SET_ENABLE_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_ENABLE_LATCH = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_ARRAY = 8'h03;
  localparam logic [7:0] OP_WRITE_ARRAY = 8'h02;

  // ****************************************************************
  // Status register layout and reset values.
  // ****************************************************************
  localparam int ST_READY_BIT = 0;
  localparam int ST_ENABLE_LATCH_BIT = 1;
  localparam int ST_BP_LOW_BIT = 2;
  localparam int ST_BP_HIGH_BIT = 3;
  localparam int ST_PIN_ENABLE_BIT = 7;
  localparam logic [7:0] STATUS_BUSY_VALUE = 8'hFF;
  localparam logic ENABLE_LATCH_RESET = 1'b0;

  // Block protect levels as {block_protect_high, block_protect_low}.
  localparam logic [1:0] BP_NONE = 2'b00;
  localparam logic [1:0] BP_QUARTER = 2'b01;
  localparam logic [1:0] BP_HALF = 2'b10;
  localparam logic [1:0] BP_ALL = 2'b11;

  // ****************************************************************
  // Timing of the self-timed write cycle.
  // ****************************************************************
  localparam int CLOCK_HZ = 50_000_000;
  localparam int WRITE_CYCLE_US = 5000;
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_US * (CLOCK_HZ / 1_000_000);

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDRESS = 3'b001,
    ST_READ_OUT = 3'b011,
    ST_WRITE_IN = 3'b010,
    ST_STATUS_OUT = 3'b110,
    ST_STATUS_IN = 3'b111,
    ST_IGNORE = 3'b100
  } link_state_t;

  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_ARRAY = 2'b01,
    KIND_STATUS = 2'b10
  } commit_kind_t;

  typedef struct packed {
    logic protect_pin_enable;
    logic block_protect_high;
    logic block_protect_low;
  } nv_status_t;

  localparam nv_status_t NV_RESET = 3'b000;

endpackage

/* tb/spi_master_model.sv */
`timescale 1ns/1ps
// ****
// Mode 0 master; sck runs only inside frames, data moves while sck is low.
// ****
module spi_master_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic lclk;
  logic oe_seen;

  // Free-running 48 ns reference, offset so it never lines up with the system clock.
  initial begin
    lclk = 1'b0;
    sck = 1'b0;
    cs_n <= 1'b1; // Deferred, so the frame reset sees a real edge at time zero.
    si = 1'b0;
    oe_seen = 1'b0;
    #7;
    forever #24 lclk = ~lclk;
  end

  // A fresh falling select edge starts every frame.
  task automatic open_frame();
    @(posedge lclk);
    cs_n <= 1'b0;
    oe_seen = 1'b0;
  endtask

  // One byte each way, most significant bit first; so is taken before sck rises.
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(negedge lclk);
      sck <= 1'b0;
      si <= tx[i];
      @(posedge lclk);
      rx[i] = so;
      oe_seen = oe_seen | so_oe;
      sck <= 1'b1;
    end
  endtask

  // Select rises in the low phase after the last bit and stays high far beyond 100 ns.
  task automatic close_frame();
    @(negedge lclk);
    sck <= 1'b0;
    @(posedge lclk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (6) @(posedge lclk);
  endtask
endmodule

/* tb/spi_eeprom_access_protect_chk.sv */
`timescale 1ns/1ps
// ****
// Port checks; the busy stretch is counted because it is far longer than a repetition.
// ****
module spi_eeprom_access_protect_chk
  import eeprom_pkg::*;
#(
  parameter int unsigned WRITE_CYCLE_CYCLES_P = WRITE_CYCLE_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic write_busy
);
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;

  // Cycles seen with busy high in the current stretch.
  assign busy_cnt_nxt = write_busy ? busy_cnt_r + 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_cnt_r <= 32'h0000_0000;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  busy_len_a: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(write_busy) |-> busy_cnt_r == WRITE_CYCLE_CYCLES_P) else $error("busy length wrong");
  busy_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(write_busy) |=> write_busy [*8]) else $error("busy dropped early");
  busy_after_cs_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(write_busy) |-> $past(cs_n, 1) && $past(cs_n, 2)) else $error("busy while selected");
  busy_status_a: assert property (@(posedge clock) disable iff (!arst_n)
    write_busy && so_oe |-> so) else $error("output zero during busy");
  oe_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    cs_n |-> !so_oe) else $error("output on while deselected");
  so_idle_a: assert property (@(posedge clock) disable iff (!arst_n)
    !so_oe |-> !so) else $error("data line not parked");
  so_fall_a: assert property (@(posedge clock) disable iff (!arst_n)
    so_oe && $changed(so) |-> !sck) else $error("output moved with sck high");
  oe_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    so_oe && !cs_n |=> so_oe || cs_n) else $error("output dropped in frame");

  cover property (@(posedge clock) disable iff (!arst_n) $rose(write_busy));
  cover property (@(posedge clock) disable iff (!arst_n) $rose(so_oe));
  cover property (@(posedge clock) disable iff (!arst_n) !wp_n && write_busy);
endmodule

/* tb/spi_eeprom_access_protect_bench.sv */
`timescale 1ns/1ps
module spi_eeprom_access_protect_bench
  import eeprom_pkg::*;
;
  // A short write cycle keeps the run small; it still outlasts a few frames.
  localparam int unsigned CYC = 300;
  localparam int LIMIT = 40000;
  logic clock = 1'b0;
  logic arst_n;
  logic wp_n = 1'b1;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  logic write_busy;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] q[$];
  logic [7:0] d[$];
  logic [7:0] exp_mem[int];
  logic [15:0] probe[3] = '{16'h5FFF, 16'h6000, 16'h4000};
  logic [15:0] a;
  logic [7:0] v;
  bit prot;

  always #10 clock = ~clock;

  spi_master_model spi_master_model_i (.sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe));
  spi_eeprom_access_protect #(.WRITE_CYCLE_CYCLES_P(CYC)) spi_eeprom_access_protect_i (
    .clock(clock), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so(so), .so_oe(so_oe), .write_busy(write_busy));

  // ****
  // Access tasks
  // ****
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_sim();
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One whole frame; every byte sent returns the byte seen on so.
  task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] r;
    rx = {};
    spi_master_model_i.open_frame();
    foreach (tx[i]) begin
      spi_master_model_i.xbyte(tx[i], r);
      rx.push_back(r);
    end
    spi_master_model_i.close_frame();
  endtask

  // Bounded wait; an ignored write never raises busy and falls straight through.
  task automatic wait_idle();
    int n;
    n = 0;
    while (write_busy !== 1'b0 && n < 2 * CYC) begin
      @(posedge clock);
      n++;
    end
    if (n >= 2 * CYC) check("busy_end", 8'h00, 8'h01);
  endtask

  task automatic st_chk(input logic [7:0] e);
    logic [7:0] rx[$];
    xfer({OP_READ_STATUS, 8'h00}, rx);
    check("status", e, rx[1]);
  endtask

  task automatic wsr(input logic [7:0] val);
    logic [7:0] rx[$];
    xfer({OP_SET_ENABLE_LATCH}, rx);
    xfer({OP_WRITE_STATUS, val}, rx);
    wait_idle();
  endtask

  task automatic wr(input logic [15:0] ad, input logic [7:0] dq[$], input bit en);
    logic [7:0] tx[$];
    logic [7:0] rx[$];
    tx = {OP_WRITE_ARRAY, ad[15:8], ad[7:0]};
    foreach (dq[i]) tx.push_back(dq[i]);
    if (en) xfer({OP_SET_ENABLE_LATCH}, rx);
    xfer(tx, rx);
    wait_idle();
  endtask

  task automatic rd_chk(input logic [15:0] ad, input logic [7:0] e[$]);
    logic [7:0] tx[$];
    logic [7:0] rx[$];
    tx = {OP_READ_ARRAY, ad[15:8], ad[7:0]};
    foreach (e[i]) tx.push_back(8'h00);
    xfer(tx, rx);
    foreach (e[i]) check("read_data", e[i], rx[i + 3]);
  endtask

  // Cuts a hung run short; the ceiling is about three times the expected length.
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      check("timeout", 8'h00, 8'h01);
      end_sim();
    end
  end

  // Main sequence; reset is driven from time zero so every asynchronous reset sees an edge.
  initial begin
    arst_n <= 1'b0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    st_chk(8'h00);
    xfer({8'h0E}, q);
    st_chk(8'h02);
    xfer({OP_CLEAR_ENABLE_LATCH}, q);
    st_chk(8'h00);
    xfer({OP_SET_ENABLE_LATCH}, q);
    xfer({OP_WRITE_ARRAY, 8'h7F, 8'hFF, 8'h55, 8'h66}, q);
    st_chk(8'hFF);
    xfer({OP_SET_ENABLE_LATCH}, q);
    xfer({OP_READ_ARRAY, 8'h00, 8'h00, 8'h00}, q);
    check("busy_read_oe", 8'h00, {7'h00, spi_master_model_i.oe_seen});
    wait_idle();
    st_chk(8'h00);
    wr(16'h0000, {8'h77}, 1'b1);
    rd_chk(16'h7FFF, {8'h55, 8'h77});
    rd_chk(16'h7FC0, {8'h66});
    rd_chk(16'hFFFF, {8'h55});
    wr(16'h0000, {8'h12}, 1'b0);
    rd_chk(16'h0000, {8'h77});
    xfer({8'hFF, 8'h00, 8'h00}, q);
    check("unknown_oe", 8'h00, {7'h00, spi_master_model_i.oe_seen});
    for (int i = 0; i < 65; i++) d.push_back(8'(i));
    wr(16'h0240, d, 1'b1);
    rd_chk(16'h0240, {8'h40, 8'h01});
    // Every protect level against probes on both sides of the quarter boundary and at the start of the half.
    for (int lv = 0; lv < 4; lv++) begin
      wsr(8'(lv << 2));
      st_chk(8'(lv << 2));
      for (int p = 0; p < 3; p++) begin
        a = probe[p];
        v = 8'(lv * 16 + p);
        prot = (lv == 3) || (lv == 2 && a >= 16'h4000) || (lv == 1 && a >= 16'h6000);
        if (!prot) exp_mem[a] = v;
        wr(a, {v}, 1'b1);
        rd_chk(a, {exp_mem[a]});
      end
    end
    wsr(8'h80);
    st_chk(8'h80);
    @(posedge clock);
    wp_n <= 1'b0;
    wsr(8'h00);
    // The enable latch stays set: the rejected status write starts no cycle to clear it.
    st_chk(8'h82);
    wr(16'h0000, {8'h99}, 1'b1);
    rd_chk(16'h0000, {8'h99});
    @(posedge clock);
    wp_n <= 1'b1;
    wsr(8'h00);
    st_chk(8'h00);
    end_sim();
  end
endmodule

bind spi_eeprom_access_protect spi_eeprom_access_protect_chk #(
  .WRITE_CYCLE_CYCLES_P(WRITE_CYCLE_CYCLES_P)
) spi_eeprom_access_protect_chk_i (
  .clock(clock), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
  .so(so), .so_oe(so_oe), .write_busy(write_busy));
